// ### src/ulap_uart.sv
// serial transceiver core with loopback, auto-baud routing and sleep/idle handling
// Summary of operation
// - loopback feeds the internal transmit line into the receive logic
// - in loopback the external receive pin never reaches the receiver
// - in loopback the transmit pin keeps working as normal
// - pin select 01 in loopback: rts works, cts unused
// - pin select 10 in loopback: rts routed into cts, cts pin ignored
// - pin select 11 keeps baud clock out; 00 and 11 leave handshake unused
// - auto-baud routes the receive pin to the capture channel
// - auto-baud disconnects the capture channel's own pin
// - auto-baud routing only with module enabled and loopback off
// - sleep aborts transmission and drives transmit pin high
// - sleep aborts reception; baud generator, transmitter and receiver all stop while asleep
// - in sleep a receive falling edge sets receive interrupt when enabled
// - receive interrupt select does not affect wake interrupt
// - no wake interrupt while module is disabled
// - stop-in-idle zero keeps running in idle, one halts
// - halting in idle aborts transfers in progress
//
// Added by the designer: the strobed register port and the placing of the registers.
module ulap_uart (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic sleep_i,
  input wire logic idle_i,
  input wire logic serial_in_pin_i,
  input wire logic clear_to_send_in_n_i,
  input wire logic capture_pin_i,
  output logic serial_out_pin_o,
  output logic request_to_send_out_n_o,
  output logic baud_clock_out_o,
  output logic capture_in_o,
  output logic rx_irq_flag_o,
  output logic tx_irq_flag_o
);
  // ==========================================================================
  // pin synchronisers
  logic [2:0] pins_sync;
  logic rx_pin_s;
  logic cts_pin_n_s;
  logic cap_pin_s;
  ulap_sync #(.WIDTH(3), .RST_VAL(3'b111)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i({serial_in_pin_i, clear_to_send_in_n_i, capture_pin_i}),
    .sync_o(pins_sync)
  );
  assign rx_pin_s = pins_sync[2];
  assign cts_pin_n_s = pins_sync[1];
  assign cap_pin_s = pins_sync[0];

  // ==========================================================================
  // registers
  logic [15:0] mode_control_r;
  logic tx_isel_r;
  logic tx_break_r;
  logic tx_en_r;
  logic [1:0] rx_isel_r;
  logic addr_det_r;
  logic frame_err_r;
  logic overrun_r;
  logic rx_avail_r;
  logic [7:0] transmit_holding_r;
  logic tx_full_r;
  logic [7:0] receive_holding_r;
  logic [15:0] baud_divisor_r;
  logic [15:0] irq_flags_r;
  logic [15:0] irq_en_r;
  logic [15:0] irq_prio_r;
  logic [15:0] rdata_nxt;

  logic module_en;
  logic loopback;
  logic [1:0] pin_sel;
  logic run;
  logic wr_mode;
  logic wr_status;
  logic wr_tx_hold;
  logic rd_rx_hold;

  assign module_en = mode_control_r[ulap_pkg::MODE_ENABLE_BIT];
  assign loopback = mode_control_r[ulap_pkg::MODE_LOOPBACK_BIT];
  assign pin_sel = mode_control_r[ulap_pkg::MODE_PIN_SEL_HI:ulap_pkg::MODE_PIN_SEL_LO];
  // halted while disabled, asleep, or idle with stop-in-idle set
  assign run = module_en & ~sleep_i & ~(idle_i & mode_control_r[ulap_pkg::MODE_STOP_IDLE_BIT]);
  assign wr_mode = reg_wr_i & (reg_addr_i == ulap_pkg::ADDR_MODE);
  assign wr_status = reg_wr_i & (reg_addr_i == ulap_pkg::ADDR_STATUS);
  assign wr_tx_hold = reg_wr_i & (reg_addr_i == ulap_pkg::ADDR_TX_HOLD);
  assign rd_rx_hold = reg_rd_i & (reg_addr_i == ulap_pkg::ADDR_RX_HOLD);

  // ==========================================================================
  // baud tick generator
  logic [15:0] baud_cnt_r;
  logic tick_r;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      baud_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (!run) begin
      baud_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (baud_cnt_r >= baud_divisor_r) begin
      baud_cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      baud_cnt_r <= baud_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // baud clock out toggles every tick, held low unless pin select 11 and running
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      baud_clock_out_o <= 1'b0;
    end else if (pin_sel != ulap_pkg::PIN_SEL_BCLK || !run) begin
      baud_clock_out_o <= 1'b0;
    end else if (tick_r) begin
      baud_clock_out_o <= ~baud_clock_out_o;
    end
  end

  // ==========================================================================
  // handshake routing
  logic cts_eff_n;
  always_comb begin
    cts_eff_n = 1'b0;
    if (pin_sel == ulap_pkg::PIN_SEL_RTS_CTS) begin
      cts_eff_n = loopback ? request_to_send_out_n_o : cts_pin_n_s;
    end
  end

  // with pin select 01 or 10, rts asserted low while running and the receive holding register has room; held high otherwise
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      request_to_send_out_n_o <= 1'b1;
    end else if (pin_sel == ulap_pkg::PIN_SEL_RTS || pin_sel == ulap_pkg::PIN_SEL_RTS_CTS) begin
      request_to_send_out_n_o <= ~(run & ~rx_avail_r);
    end else begin
      request_to_send_out_n_o <= 1'b1;
    end
  end

  // ==========================================================================
  // transmitter
  ulap_pkg::ulap_tx_state_t tx_state_r;
  logic [3:0] tx_ticks_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_shift_r;
  logic tx_load;
  logic tx_bit_end;
  assign tx_load = run && tx_state_r == ulap_pkg::TX_IDLE && tx_full_r && tx_en_r && !cts_eff_n;
  assign tx_bit_end = tick_r && tx_ticks_r == ulap_pkg::TICKS_LAST;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_r <= ulap_pkg::TX_IDLE;
      tx_ticks_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_shift_r <= 8'h00;
    end else if (!run) begin
      tx_state_r <= ulap_pkg::TX_IDLE;
      tx_ticks_r <= 4'h0;
      tx_bit_r <= 3'h0;
    end else begin
      if (tick_r) begin
        tx_ticks_r <= tx_ticks_r + 4'h1;
      end
      case (tx_state_r)
        ulap_pkg::TX_IDLE: begin
          tx_ticks_r <= 4'h0;
          if (tx_load) begin
            tx_shift_r <= transmit_holding_r;
            tx_state_r <= ulap_pkg::TX_START;
          end
        end
        ulap_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_state_r <= ulap_pkg::TX_DATA;
            tx_bit_r <= 3'h0;
          end
        end
        ulap_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == ulap_pkg::DATA_BITS_LAST) begin
              tx_state_r <= ulap_pkg::TX_STOP;
            end
          end
        end
        ulap_pkg::TX_STOP: begin
          if (tx_bit_end) begin
            tx_state_r <= ulap_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_state_r <= ulap_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // transmit line, shared by the pin and the loopback path
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_out_pin_o <= 1'b1;
    end else if (!run) begin
      serial_out_pin_o <= 1'b1;
    end else begin
      case (tx_state_r)
        ulap_pkg::TX_START: serial_out_pin_o <= 1'b0;
        ulap_pkg::TX_DATA: serial_out_pin_o <= tx_shift_r[0];
        ulap_pkg::TX_IDLE: serial_out_pin_o <= ~tx_break_r;
        default: serial_out_pin_o <= 1'b1;
      endcase
    end
  end

  // ==========================================================================
  // receive input selection
  logic rx_line;
  assign rx_line = loopback ? serial_out_pin_o : rx_pin_s;

  // capture channel input selection
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      capture_in_o <= 1'b1;
    end else if (mode_control_r[ulap_pkg::MODE_AUTO_BAUD_BIT] && module_en && !loopback) begin
      capture_in_o <= rx_pin_s;
    end else begin
      capture_in_o <= cap_pin_s;
    end
  end

  // ==========================================================================
  // receiver
  ulap_pkg::ulap_rx_state_t rx_state_r;
  logic [3:0] rx_ticks_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_shift_r;
  logic rx_done;
  logic rx_bad_stop;
  logic rx_bit_end;
  assign rx_bit_end = tick_r && rx_ticks_r == ulap_pkg::TICKS_LAST;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_r <= ulap_pkg::RX_IDLE;
      rx_ticks_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_shift_r <= 8'h00;
      rx_done <= 1'b0;
      rx_bad_stop <= 1'b0;
    end else if (!run) begin
      rx_state_r <= ulap_pkg::RX_IDLE;
      rx_ticks_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick_r) begin
        rx_ticks_r <= rx_ticks_r + 4'h1;
      end
      case (rx_state_r)
        ulap_pkg::RX_IDLE: begin
          rx_ticks_r <= 4'h0;
          if (!rx_line) begin
            rx_state_r <= ulap_pkg::RX_START;
          end
        end
        ulap_pkg::RX_START: begin
          if (tick_r && rx_ticks_r == ulap_pkg::TICKS_HALF) begin
            rx_ticks_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_state_r <= rx_line ? ulap_pkg::RX_IDLE : ulap_pkg::RX_DATA;
          end
        end
        ulap_pkg::RX_DATA: begin
          if (rx_bit_end) begin
            rx_shift_r <= {rx_line, rx_shift_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == ulap_pkg::DATA_BITS_LAST) begin
              rx_state_r <= ulap_pkg::RX_STOP;
            end
          end
        end
        ulap_pkg::RX_STOP: begin
          if (rx_bit_end) begin
            rx_done <= 1'b1;
            rx_bad_stop <= ~rx_line;
            rx_state_r <= ulap_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= ulap_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // wake-up edge detect on the synchronised receive pin
  logic rx_pin_prev_r;
  logic wake_event;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_pin_prev_r <= 1'b1;
    end else begin
      rx_pin_prev_r <= rx_pin_s;
    end
  end
  assign wake_event = sleep_i && rx_pin_prev_r && !rx_pin_s && mode_control_r[ulap_pkg::MODE_WAKE_BIT]
                      && irq_en_r[ulap_pkg::IRQ_RX_BIT] && module_en;

  // ==========================================================================
  // mode, divisor, enable and priority registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_control_r <= ulap_pkg::MODE_RST;
      baud_divisor_r <= ulap_pkg::BAUD_DIV_RST;
      irq_en_r <= ulap_pkg::IRQ_EN_RST;
      irq_prio_r <= ulap_pkg::IRQ_PRIO_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ulap_pkg::ADDR_MODE: mode_control_r <= reg_wdata_i & ulap_pkg::MODE_WMASK;
        ulap_pkg::ADDR_BAUD_DIV: baud_divisor_r <= reg_wdata_i;
        ulap_pkg::ADDR_IRQ_EN: irq_en_r <= reg_wdata_i;
        ulap_pkg::ADDR_IRQ_PRIO: irq_prio_r <= reg_wdata_i & ulap_pkg::IRQ_PRIO_WMASK;
        default: begin
        end
      endcase
    end
  end

  // status control bits
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_isel_r <= 1'b0;
      tx_break_r <= 1'b0;
      tx_en_r <= 1'b0;
      rx_isel_r <= 2'b00;
      addr_det_r <= 1'b0;
    end else begin
      if (wr_status) begin
        tx_isel_r <= reg_wdata_i[ulap_pkg::STA_TX_ISEL_BIT];
        tx_break_r <= reg_wdata_i[ulap_pkg::STA_TX_BREAK_BIT];
        tx_en_r <= reg_wdata_i[ulap_pkg::STA_TX_EN_BIT] & module_en;
        rx_isel_r <= reg_wdata_i[ulap_pkg::STA_RX_ISEL_HI:ulap_pkg::STA_RX_ISEL_LO];
        addr_det_r <= reg_wdata_i[ulap_pkg::STA_ADDR_DET_BIT];
      end else if (!module_en) begin
        tx_en_r <= 1'b0;
      end
    end
  end

  // transmit holding register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      transmit_holding_r <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (wr_tx_hold && tx_en_r) begin
      transmit_holding_r <= reg_wdata_i[7:0];
      tx_full_r <= 1'b1;
    end else if (tx_load) begin
      tx_full_r <= 1'b0;
    end
  end

  // receive holding register and its status; new data wins over a read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      receive_holding_r <= 8'h00;
      rx_avail_r <= 1'b0;
      frame_err_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      if (rx_done && rx_avail_r && !rd_rx_hold) begin
        overrun_r <= 1'b1;
      end else if (wr_status && !reg_wdata_i[ulap_pkg::STA_OVERRUN_BIT]) begin
        overrun_r <= 1'b0;
      end
      if (rx_done && (!rx_avail_r || rd_rx_hold)) begin
        receive_holding_r <= rx_shift_r;
        frame_err_r <= rx_bad_stop;
        rx_avail_r <= 1'b1;
      end else if (rd_rx_hold) begin
        rx_avail_r <= 1'b0;
      end
    end
  end

  // interrupt flags: hardware set wins over a software write in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_flags_r <= ulap_pkg::IRQ_FLAGS_RST;
    end else begin
      if (reg_wr_i && reg_addr_i == ulap_pkg::ADDR_IRQ_FLAGS) begin
        irq_flags_r <= reg_wdata_i;
      end
      if (rx_done || wake_event) begin
        irq_flags_r[ulap_pkg::IRQ_RX_BIT] <= 1'b1;
      end
      if (tx_load) begin
        irq_flags_r[ulap_pkg::IRQ_TX_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_irq_flag_o <= 1'b0;
      tx_irq_flag_o <= 1'b0;
    end else begin
      rx_irq_flag_o <= irq_flags_r[ulap_pkg::IRQ_RX_BIT];
      tx_irq_flag_o <= irq_flags_r[ulap_pkg::IRQ_TX_BIT];
    end
  end

  // ==========================================================================
  // read back
  always_comb begin
    rdata_nxt = 16'h0000;
    case (reg_addr_i)
      ulap_pkg::ADDR_MODE: rdata_nxt = mode_control_r;
      ulap_pkg::ADDR_STATUS: begin
        rdata_nxt[ulap_pkg::STA_TX_ISEL_BIT] = tx_isel_r;
        rdata_nxt[ulap_pkg::STA_TX_BREAK_BIT] = tx_break_r;
        rdata_nxt[ulap_pkg::STA_TX_EN_BIT] = tx_en_r;
        rdata_nxt[ulap_pkg::STA_TX_FULL_BIT] = tx_full_r;
        rdata_nxt[ulap_pkg::STA_TX_EMPTY_BIT] = ~tx_full_r & (tx_state_r == ulap_pkg::TX_IDLE);
        rdata_nxt[ulap_pkg::STA_RX_ISEL_HI:ulap_pkg::STA_RX_ISEL_LO] = rx_isel_r;
        rdata_nxt[ulap_pkg::STA_ADDR_DET_BIT] = addr_det_r;
        rdata_nxt[ulap_pkg::STA_RX_IDLE_BIT] = rx_state_r == ulap_pkg::RX_IDLE;
        rdata_nxt[ulap_pkg::STA_FRAME_ERR_BIT] = frame_err_r;
        rdata_nxt[ulap_pkg::STA_OVERRUN_BIT] = overrun_r;
        rdata_nxt[ulap_pkg::STA_RX_AVAIL_BIT] = rx_avail_r;
      end
      ulap_pkg::ADDR_RX_HOLD: rdata_nxt = {8'h00, receive_holding_r};
      ulap_pkg::ADDR_BAUD_DIV: rdata_nxt = baud_divisor_r;
      ulap_pkg::ADDR_IRQ_FLAGS: rdata_nxt = irq_flags_r;
      ulap_pkg::ADDR_IRQ_EN: rdata_nxt = irq_en_r;
      ulap_pkg::ADDR_IRQ_PRIO: rdata_nxt = irq_prio_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end
endmodule : ulap_uart

// ### src/ulap_pkg.sv
// constants shared by the serial transceiver with loopback, auto-baud and power handling
package ulap_pkg;
  // ==========================================================================
  // register indexes on the plain register port
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_TX_HOLD = 4'h2;
  localparam logic [3:0] ADDR_RX_HOLD = 4'h3;
  localparam logic [3:0] ADDR_BAUD_DIV = 4'h4;
  localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h5;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h6;
  localparam logic [3:0] ADDR_IRQ_PRIO = 4'h7;
  // ==========================================================================
  // reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0110;
  localparam logic [15:0] BAUD_DIV_RST = 16'h0000;
  localparam logic [15:0] IRQ_FLAGS_RST = 16'h0000;
  localparam logic [15:0] IRQ_EN_RST = 16'h0000;
  localparam logic [15:0] IRQ_PRIO_RST = 16'h4444;
  // ==========================================================================
  // writable masks
  localparam logic [15:0] MODE_WMASK = 16'hA3E7;
  localparam logic [15:0] IRQ_PRIO_WMASK = 16'h7777;
  // ==========================================================================
  // mode_control fields
  localparam int MODE_ENABLE_BIT = 15;
  localparam int MODE_STOP_IDLE_BIT = 13;
  localparam int MODE_PIN_SEL_HI = 9;
  localparam int MODE_PIN_SEL_LO = 8;
  localparam int MODE_WAKE_BIT = 7;
  localparam int MODE_LOOPBACK_BIT = 6;
  localparam int MODE_AUTO_BAUD_BIT = 5;
  // ==========================================================================
  // status_control fields
  localparam int STA_TX_ISEL_BIT = 15;
  localparam int STA_TX_BREAK_BIT = 11;
  localparam int STA_TX_EN_BIT = 10;
  localparam int STA_TX_FULL_BIT = 9;
  localparam int STA_TX_EMPTY_BIT = 8;
  localparam int STA_RX_ISEL_HI = 7;
  localparam int STA_RX_ISEL_LO = 6;
  localparam int STA_ADDR_DET_BIT = 5;
  localparam int STA_RX_IDLE_BIT = 4;
  localparam int STA_FRAME_ERR_BIT = 2;
  localparam int STA_OVERRUN_BIT = 1;
  localparam int STA_RX_AVAIL_BIT = 0;
  // ==========================================================================
  // interrupt flag and enable positions
  localparam int IRQ_TX_BIT = 10;
  localparam int IRQ_RX_BIT = 9;
  // ==========================================================================
  // pin enable settings
  localparam logic [1:0] PIN_SEL_TXRX = 2'b00;
  localparam logic [1:0] PIN_SEL_RTS = 2'b01;
  localparam logic [1:0] PIN_SEL_RTS_CTS = 2'b10;
  localparam logic [1:0] PIN_SEL_BCLK = 2'b11;
  // ==========================================================================
  // timing: sixteen baud ticks per bit, sample at mid bit
  localparam logic [3:0] TICKS_LAST = 4'hF;
  localparam logic [3:0] TICKS_HALF = 4'h7;
  localparam logic [2:0] DATA_BITS_LAST = 3'h7;
  // ==========================================================================
  // state machines
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } ulap_tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } ulap_rx_state_t;
endpackage : ulap_pkg

// ### src/ulap_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
module ulap_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : ulap_sync

// ### tb/ulap_uart_props.sv
// checker: port-level properties of the serial transceiver
module ulap_uart_props (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic sleep_i,
  input wire logic idle_i,
  input wire logic serial_in_pin_i,
  input wire logic capture_pin_i,
  input wire logic serial_out_pin_o,
  input wire logic baud_clock_out_o,
  input wire logic capture_in_o,
  input wire logic rx_irq_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mode_r;
  logic ien_r;
  logic route;
  logic running;
  logic wake_ok;
  // ==========================================
  // shadow of mode and receive enable
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= ulap_pkg::MODE_RST;
    end else if (reg_wr_i && reg_addr_i == ulap_pkg::ADDR_MODE) begin
      mode_r <= reg_wdata_i & ulap_pkg::MODE_WMASK;
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ien_r <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == ulap_pkg::ADDR_IRQ_EN) begin
      ien_r <= reg_wdata_i[9];
    end
  end
  assign route = mode_r[15] & mode_r[5] & !mode_r[6];
  assign running = mode_r[15] & !sleep_i & !(idle_i & mode_r[13]);
  assign wake_ok = mode_r[15] & mode_r[7] & ien_r;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wake_edge;
    sleep_i && wake_ok && $fell(serial_in_pin_i);
  endsequence
  sequence s_off_quiet;
    (sleep_i && !mode_r[15] && !reg_wr_i)[*3] ##0 !rx_irq_flag_o;
  endsequence
  // ==========================================
  // properties
  a_stop_tx_high: assert property (!running |=> serial_out_pin_o)
    else $error("transmit pin low while halted");
  a_wake_irq: assert property (s_wake_edge |-> ##[1:8] rx_irq_flag_o)
    else $error("wake interrupt missing");
  a_no_wake_off: assert property (s_off_quiet |=> !rx_irq_flag_o)
    else $error("wake interrupt while disabled");
  a_route_rx: assert property ((route && $stable(serial_in_pin_i))[*4] |-> capture_in_o == serial_in_pin_i)
    else $error("capture not fed from receive pin");
  a_route_own: assert property ((!route && $stable(capture_pin_i))[*4] |-> capture_in_o == capture_pin_i)
    else $error("capture not fed from its own pin");
  a_bclk_off: assert property ((mode_r[9:8] != 2'b11)[*2] |=> !baud_clock_out_o)
    else $error("baud clock out active");
  a_rdata_zero: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  a_mode_read: assert property (reg_rd_i && reg_addr_i == ulap_pkg::ADDR_MODE |=> reg_rdata_o == $past(mode_r))
    else $error("mode readback wrong");
endmodule : ulap_uart_props

// ### tb/ulap_remote.sv
// remote serial device: drives the receive line, decodes the transmit line
module ulap_remote (
  input wire logic core_clk_i,
  input wire logic tx_pin_i,
  output logic rx_line_o,
  output logic cts_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_byte = 8'h00;
  logic [7:0] shift_r;
  initial rx_line_o = 1'b1;
  // never ready: the transmitter goes only where cts is unused or where loopback routes rts into cts
  assign cts_n_o = 1'b1;
  task automatic set_line(input logic v);
    rx_line_o <= v;
  endtask : set_line
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_i);
      rx_line_o <= frame[i];
      repeat (15) @(posedge core_clk_i);
    end
  endtask : send
  always begin
    @(negedge tx_pin_i);
    repeat (8) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge core_clk_i);
      shift_r[i] = tx_pin_i;
    end
    repeat (16) @(posedge core_clk_i);
    last_byte = shift_r;
  end
endmodule : ulap_remote

// ### tb/tb_ulap_uart.sv
// testbench: register-driven scenarios for the serial transceiver
module tb_ulap_uart;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic sleep_i = 1'b0;
  logic idle_i = 1'b0;
  logic capture_pin_i = 1'b1;
  logic serial_in_pin_i, clear_to_send_in_n_i, serial_out_pin_o, request_to_send_out_n_o;
  logic baud_clock_out_o, capture_in_o, rx_irq_flag_o, tx_irq_flag_o;
  logic [15:0] reg_rdata_o;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  always #5 core_clk_i = ~core_clk_i;
  ulap_uart DUT (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .sleep_i, .idle_i, .serial_in_pin_i, .clear_to_send_in_n_i, .capture_pin_i, .serial_out_pin_o,
    .request_to_send_out_n_o, .baud_clock_out_o, .capture_in_o, .rx_irq_flag_o, .tx_irq_flag_o);
  ulap_remote remote (.core_clk_i, .tx_pin_i(serial_out_pin_o), .rx_line_o(serial_in_pin_i),
    .cts_n_o(clear_to_send_in_n_i));
  // ==========================================
  // bus and compare tasks
  task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string name, input logic exp);
    logic got;
    @(negedge core_clk_i);
    got = name == "tx" ? serial_out_pin_o : name == "cap" ? capture_in_o : name == "rts" ? request_to_send_out_n_o
      : name == "txf" ? tx_irq_flag_o : rx_irq_flag_o;
    chk_word(name, 16'(exp), 16'(got));
    @(posedge core_clk_i);
  endtask : chk_bit
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp, input string name);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk_word(name, exp, reg_rdata_o);
  endtask : rd_reg
  task automatic test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd_reg(ulap_pkg::ADDR_MODE, ulap_pkg::MODE_RST, "mode");
    rd_reg(ulap_pkg::ADDR_STATUS, 16'h0110, "status");
    rd_reg(ulap_pkg::ADDR_IRQ_PRIO, 16'h4444, "prio");
    rd_reg(4'h9, 16'h0000, "unmapped");
    wr_reg(ulap_pkg::ADDR_BAUD_DIV, 16'h0000);
    wr_reg(ulap_pkg::ADDR_MODE, 16'h8000);
    for (int s = 0; s < 4; s++) begin
      wr_reg(ulap_pkg::ADDR_MODE, 16'h8040 | (16'(s) << 8));
      wr_reg(ulap_pkg::ADDR_STATUS, 16'h0400);
      fork
        remote.send(8'h00);
        wr_reg(ulap_pkg::ADDR_TX_HOLD, 16'h00A0 + 16'(s));
      join
      repeat (60) @(posedge core_clk_i);
      rd_reg(ulap_pkg::ADDR_RX_HOLD, 16'h00A0 + 16'(s), "loop rx");
      chk_word("line", 16'h00A0 + 16'(s), {8'h00, remote.last_byte});
      chk_bit("rts", s != 1 && s != 2);
    end
    chk_bit("txf", 1'b1);
    wr_reg(ulap_pkg::ADDR_MODE, 16'h8020);
    remote.set_line(1'b0);
    repeat (5) @(posedge core_clk_i);
    chk_bit("cap", 1'b0);
    wr_reg(ulap_pkg::ADDR_MODE, 16'h8060);
    repeat (5) @(posedge core_clk_i);
    chk_bit("cap", 1'b1);
    remote.set_line(1'b1);
    repeat (200) @(posedge core_clk_i);
    wr_reg(ulap_pkg::ADDR_MODE, 16'h8000);
    wr_reg(ulap_pkg::ADDR_STATUS, 16'h04C0);
    wr_reg(ulap_pkg::ADDR_TX_HOLD, 16'h0000);
    repeat (40) @(posedge core_clk_i);
    sleep_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk_bit("tx", 1'b1);
    wr_reg(ulap_pkg::ADDR_IRQ_EN, 16'h0200);
    wr_reg(ulap_pkg::ADDR_IRQ_FLAGS, 16'h0000);
    wr_reg(ulap_pkg::ADDR_MODE, 16'h8080);
    remote.send(8'h55);
    chk_bit("irq", 1'b1);
    wr_reg(ulap_pkg::ADDR_IRQ_FLAGS, 16'h0000);
    wr_reg(ulap_pkg::ADDR_MODE, 16'h0080);
    remote.send(8'h55);
    chk_bit("irq", 1'b0);
    sleep_i <= 1'b0;
    wr_reg(ulap_pkg::ADDR_MODE, 16'hA000);
    wr_reg(ulap_pkg::ADDR_STATUS, 16'h0400);
    idle_i <= 1'b1;
    wr_reg(ulap_pkg::ADDR_TX_HOLD, 16'h005A);
    repeat (200) @(posedge core_clk_i);
    chk_bit("tx", 1'b1);
    wr_reg(ulap_pkg::ADDR_MODE, 16'h8000);
    repeat (220) @(posedge core_clk_i);
    chk_word("resume", 16'h005A, {8'h00, remote.last_byte});
    test_done();
  end
endmodule : tb_ulap_uart
bind ulap_uart ulap_uart_props u_props (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .sleep_i, .idle_i, .serial_in_pin_i, .capture_pin_i, .serial_out_pin_o,
  .baud_clock_out_o, .capture_in_o, .rx_irq_flag_o);
